// *** cis_pkg.sv ***
// Shared constants and carriers for the core pin-boundary sampling block.
package cis_pkg;
	// ------------------------------------------------------------
	// Transfer size codes
	// ------------------------------------------------------------
	localparam logic [1:0] SIZE_BYTE = 2'h0; // Eight-bit transfer.
	localparam logic [1:0] SIZE_HALF = 2'h1; // Sixteen-bit transfer.
	localparam logic [1:0] SIZE_WORD = 2'h2; // Thirty-two-bit transfer.
	localparam logic [1:0] SIZE_BAD  = 2'h3; // Not a legal size.

	// ------------------------------------------------------------
	// Next transfer type codes
	// ------------------------------------------------------------
	localparam logic [1:0] NEXT_TRANSFER_TYPE_IDLE = 2'h0; // Address-only or idle next.
	localparam logic [1:0] NEXT_TRANSFER_TYPE_COPR = 2'h1; // Coprocessor register next.
	localparam logic [1:0] NEXT_TRANSFER_TYPE_NSEQ = 2'h2; // New address next.
	localparam logic [1:0] NEXT_TRANSFER_TYPE_SEQ  = 2'h3; // Incremental address next.

	// ------------------------------------------------------------
	// Test-port instruction and chain codes (plain defaults)
	// ------------------------------------------------------------
	localparam logic [3:0] INSTR_EXTEST  = 4'h0; // Drives boundary cells.
	localparam logic [3:0] INSTR_SAMPLE  = 4'h3; // Samples boundary cells.
	localparam logic [3:0] INSTR_PRELOAD = 4'h4; // Loads boundary cells.
	localparam logic [3:0] INSTR_CLAMP   = 4'h5; // Optional clamp.
	localparam logic [3:0] INSTR_HIGHZ   = 4'h7; // Optional float.
	localparam logic [3:0] INSTR_CLAMPZ  = 4'h9; // Optional clamp and float.
	localparam logic [3:0] CHAIN_CORE_A  = 4'h1; // First internal chain.
	localparam logic [3:0] CHAIN_CORE_B  = 4'h2; // Second internal chain.

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int          SCAN_LEN_DEF = 8;     // Inserted scan path length.
	localparam int          DBG_SHIFT_W  = 8;     // Debug shift register width.
	localparam logic [31:0] ADDR_RST     = 32'h0; // Address after reset.
	localparam logic [31:0] DATA_RST     = 32'h0; // Data after reset.

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] addr;  // Byte address.
		logic        write; // High for a write.
		logic [1:0]  size;  // Transfer size code.
		logic [1:0]  access_protection;  // Protection code.
		logic        lock;  // Locked access.
	} cis_addr_class_s;

	typedef struct packed {
		logic tms; // Debug mode select.
		logic tdi; // Debug serial data.
	} cis_debug_in_s;
endpackage

// *** cis_core_if.sv ***
// Pin-boundary sampling and launch logic of the processor core.
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R01] Scan select low normally, high shifts scan path.
// [R02] One serial scan input and output end path.
// [R03] Both clock enables sampled on every edge.
// [R04] Bus inputs need bus enable; debug needs tick.
// [R05] Rising master clock edge is only edge.
// [R06] Debug port runs on master clock only.
// [R07] Outside logic makes tick from free test clock.
// [R08] No boundary chain; clamp instructions optional.
// [R09] No boundary instructions on internal chains.
// [R10] Both interrupt requests sampled on rising edge.
// [R11] Asynchronous interrupt sources synchronised outside.
// [R12] Address-class outputs change right after edge.
// [R13] Outside latches may delay address-class changes.
// [R14] Address may advance while bus enable low.
// [R15] Memory keeps the address of current cycle.
// [R16] Tick enable gates the debug logic advance.
// [R17] Core reset active low, asserts asynchronously.
// [R18] Size codes byte, half, word; three illegal.
module cis_core_if #(
	parameter int         SCAN_LEN     = cis_pkg::SCAN_LEN_DEF,
	parameter int         DBG_W        = cis_pkg::DBG_SHIFT_W,
	parameter logic       CLAMP_SUPPORT = 1'b0
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic                     i_core_reset_n,
	input  wire logic                     i_scan_shift_select,
	input  wire logic                     i_scan_serial_in,
	output logic                          o_scan_serial_out,
	input  wire logic                     i_bus_cycle_enable,
	input  wire logic                     i_debug_tick_enable,
	input  wire logic                     i_abort,
	input  wire logic [31:0]              i_rdata,
	input  wire cis_pkg::cis_debug_in_s   i_debug_in,
	input  wire logic                     i_debug_instr_valid,
	input  wire logic [3:0]               i_debug_instr,
	input  wire logic [3:0]               i_debug_chain,
	input  wire logic                     i_normal_interrupt_request_n,
	input  wire logic                     i_fast_interrupt_request_n,
	input  wire cis_pkg::cis_addr_class_s i_core_addr_class,
	input  wire logic [1:0]               i_core_next_transfer_type,
	input  wire logic [31:0]              i_core_wdata,
	output cis_pkg::cis_addr_class_s      o_addr_class,
	output logic [1:0]                    o_next_transfer_type,
	output logic [31:0]                   o_wdata,
	output logic                          o_size_error,
	output logic                          o_core_abort,
	output logic [31:0]                   o_core_rdata,
	output logic                          o_core_irq,
	output logic                          o_core_fiq,
	output logic                          o_bus_enable_seen,
	output logic                          o_debug_tick_seen,
	output cis_pkg::cis_debug_in_s        o_debug_sampled,
	output logic                          o_debug_serial_out,
	output logic                          o_instr_refused,
	output logic                          o_clamp_active
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [SCAN_LEN-1:0] scan_q;     // Inserted scan path cells.
	logic [DBG_W-1:0]    dbg_sh_q;   // Debug serial shift register.
	logic                refuse_d;   // Instruction refusal decision.
	logic                clamp_d;    // Clamp request decision.
	logic                boundary;   // Instruction needs boundary cells.
	logic                optional;   // Instruction is a clamp kind.
	logic                core_chain; // Internal chain is selected.
	logic [1:0]          size_safe;  // Size code after legal check.

	// ------------------------------------------------------------
	// Scan path
	// ------------------------------------------------------------
	// The cells shift only while test shifting is selected; in
	// functional use the select is low and the path holds still.
	always_ff @(posedge i_clk) begin // [R05]
		if (i_sys_rst) begin
			scan_q <= '0;
		end else if (i_scan_shift_select) begin // [R01]
			scan_q <= {scan_q[SCAN_LEN-2:0], i_scan_serial_in}; // [R02]
		end
	end

	// The far end of the path is a flop, so the output is clean.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_scan_serial_out <= 1'b0;
		end else begin
			o_scan_serial_out <= scan_q[SCAN_LEN-1]; // [R02]
		end
	end

	// ------------------------------------------------------------
	// Clock enable sampling
	// ------------------------------------------------------------
	// Both qualifiers are taken on every edge whatever their value.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_bus_enable_seen <= 1'b0;
			o_debug_tick_seen <= 1'b0;
		end else begin
			o_bus_enable_seen <= i_bus_cycle_enable; // [R03]
			o_debug_tick_seen <= i_debug_tick_enable; // [R03]
		end
	end

	// ------------------------------------------------------------
	// Bus input capture
	// ------------------------------------------------------------
	// Abort and read data are only valid on enabled edges; holding
	// them otherwise hides wait-state garbage from the core.
	always_ff @(posedge i_clk or negedge i_core_reset_n) begin // [R17]
		if (!i_core_reset_n) begin
			o_core_abort <= 1'b0;
			o_core_rdata <= cis_pkg::DATA_RST;
		end else if (i_sys_rst) begin
			o_core_abort <= 1'b0;
			o_core_rdata <= cis_pkg::DATA_RST;
		end else if (i_bus_cycle_enable) begin // [R04]
			o_core_abort <= i_abort;
			o_core_rdata <= i_rdata;
		end
	end

	// ------------------------------------------------------------
	// Interrupt sampling
	// ------------------------------------------------------------
	// The request pins are synchronous, so one flop suffices; an
	// asynchronous source must be synchronised outside.
	always_ff @(posedge i_clk or negedge i_core_reset_n) begin // [R17]
		if (!i_core_reset_n) begin
			o_core_irq <= 1'b0;
			o_core_fiq <= 1'b0;
		end else if (i_sys_rst) begin
			o_core_irq <= 1'b0;
			o_core_fiq <= 1'b0;
		end else begin
			o_core_irq <= !i_normal_interrupt_request_n; // [R10] [R11]
			o_core_fiq <= !i_fast_interrupt_request_n; // [R10]
		end
	end

	// ------------------------------------------------------------
	// Address-class launch
	// ------------------------------------------------------------
	// An illegal size becomes a word so the pins never show it.
	always_comb begin
		if (i_core_addr_class.size == cis_pkg::SIZE_BAD) begin // [R18]
			size_safe = cis_pkg::SIZE_WORD;
		end else begin
			size_safe = i_core_addr_class.size;
		end
	end

	// These outputs move on every edge, not just enabled ones; the
	// memory side must keep its own copy of the current address.
	always_ff @(posedge i_clk or negedge i_core_reset_n) begin // [R17]
		if (!i_core_reset_n) begin
			o_addr_class <= '0;
			o_size_error <= 1'b0;
		end else if (i_sys_rst) begin
			o_addr_class <= '0;
			o_size_error <= 1'b0;
		end else begin
			o_addr_class       <= i_core_addr_class; // [R12] [R14] [R15]
			o_addr_class.size  <= size_safe; // [R18]
			o_size_error       <= (i_core_addr_class.size == cis_pkg::SIZE_BAD);
		end
	end

	// Transfer type and write data follow the bus enable.
	always_ff @(posedge i_clk or negedge i_core_reset_n) begin // [R17]
		if (!i_core_reset_n) begin
			o_next_transfer_type <= cis_pkg::NEXT_TRANSFER_TYPE_IDLE;
			o_wdata              <= cis_pkg::DATA_RST;
		end else if (i_sys_rst) begin
			o_next_transfer_type <= cis_pkg::NEXT_TRANSFER_TYPE_IDLE;
			o_wdata              <= cis_pkg::DATA_RST;
		end else if (i_bus_cycle_enable) begin
			o_next_transfer_type <= i_core_next_transfer_type;
			o_wdata              <= i_core_wdata;
		end
	end

	// ------------------------------------------------------------
	// Debug port
	// ------------------------------------------------------------
	// Everything here runs on the master clock gated by the tick;
	// a free-running test clock must be turned into ticks outside.
	always_ff @(posedge i_clk) begin // [R06] [R07]
		if (i_sys_rst) begin
			o_debug_sampled <= '0;
			dbg_sh_q        <= '0;
		end else if (i_debug_tick_enable) begin // [R04] [R16]
			o_debug_sampled <= i_debug_in;
			dbg_sh_q        <= {i_debug_in.tdi, dbg_sh_q[DBG_W-1:1]};
		end
	end

	// The serial output is the low cell, refreshed only on ticks.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_debug_serial_out <= 1'b0;
		end else if (i_debug_tick_enable) begin // [R16]
			o_debug_serial_out <= dbg_sh_q[0];
		end
	end

	// ------------------------------------------------------------
	// Test-port instruction screening
	// ------------------------------------------------------------
	// There are no boundary cells, so boundary instructions only
	// make sense on chains that an integrator has added.
	always_comb begin
		boundary   = (i_debug_instr == cis_pkg::INSTR_EXTEST)
			|| (i_debug_instr == cis_pkg::INSTR_SAMPLE)
			|| (i_debug_instr == cis_pkg::INSTR_PRELOAD);
		optional   = (i_debug_instr == cis_pkg::INSTR_CLAMP)
			|| (i_debug_instr == cis_pkg::INSTR_HIGHZ)
			|| (i_debug_instr == cis_pkg::INSTR_CLAMPZ);
		core_chain = (i_debug_chain == cis_pkg::CHAIN_CORE_A)
			|| (i_debug_chain == cis_pkg::CHAIN_CORE_B);
		refuse_d   = (boundary && core_chain) // [R09]
			|| (optional && !CLAMP_SUPPORT); // [R08]
		clamp_d    = optional && CLAMP_SUPPORT; // [R08]
	end

	// The verdict is taken on a tick with a valid instruction and
	// stands until the next such instruction.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_instr_refused <= 1'b0;
			o_clamp_active  <= 1'b0;
		end else if (i_debug_tick_enable && i_debug_instr_valid) begin
			o_instr_refused <= refuse_d; // [R08] [R09]
			o_clamp_active  <= clamp_d;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst || !i_core_reset_n);

	property p_scan_hold;
		!i_scan_shift_select |=> $stable(scan_q);
	endproperty
	a_scan_hold: assert property (p_scan_hold) // [R01]
		else $error("Scan path moved while not shifting.");

	property p_scan_pass;
		i_scan_shift_select ##1 i_scan_shift_select
		|=> o_scan_serial_out == $past(scan_q[SCAN_LEN-2], 2);
	endproperty
	a_scan_pass: assert property (p_scan_pass) // [R02]
		else $error("Scan output not fed by the path.");

	// Edges taken in reset are left out of the copy checks, because the
	// disable may already have lifted when the following edge is checked.
	property p_enable_seen;
		!i_sys_rst |=> (o_bus_enable_seen == $past(i_bus_cycle_enable))
			&& (o_debug_tick_seen == $past(i_debug_tick_enable));
	endproperty
	a_enable_seen: assert property (p_enable_seen) // [R03]
		else $error("Clock enable not sampled on an edge.");

	property p_rdata_gate;
		!i_bus_cycle_enable |=> $stable(o_core_rdata) && $stable(o_core_abort);
	endproperty
	a_rdata_gate: assert property (p_rdata_gate) // [R04]
		else $error("Bus input captured without bus enable.");

	property p_rdata_take;
		i_bus_cycle_enable && i_core_reset_n && !i_sys_rst
		|=> o_core_rdata == $past(i_rdata);
	endproperty
	a_rdata_take: assert property (p_rdata_take) // [R04]
		else $error("Read data missed on an enabled edge.");

	property p_debug_gate;
		!i_debug_tick_enable ##1 !i_debug_tick_enable
		|=> $stable(o_debug_sampled) && $stable(o_debug_serial_out);
	endproperty
	a_debug_gate: assert property (p_debug_gate) // [R16] [R06]
		else $error("Debug logic advanced without a tick.");

	property p_irq_sample;
		i_core_reset_n && !i_sys_rst
		|=> o_core_irq == !$past(i_normal_interrupt_request_n)
			&& o_core_fiq == !$past(i_fast_interrupt_request_n);
	endproperty
	a_irq_sample: assert property (p_irq_sample) // [R10]
		else $error("Interrupt request not sampled on the edge.");

	property p_addr_move;
		!i_bus_cycle_enable && i_core_reset_n && !i_sys_rst
		|=> o_addr_class.addr == $past(i_core_addr_class.addr);
	endproperty
	a_addr_move: assert property (p_addr_move) // [R12] [R14]
		else $error("Address did not advance on a disabled edge.");

	property p_size_legal;
		o_addr_class.size != cis_pkg::SIZE_BAD;
	endproperty
	a_size_legal: assert property (p_size_legal) // [R18]
		else $error("Illegal transfer size on the pins.");

	property p_refuse;
		i_debug_tick_enable && i_debug_instr_valid && core_chain
		&& (i_debug_instr == cis_pkg::INSTR_EXTEST) |=> o_instr_refused;
	endproperty
	a_refuse: assert property (p_refuse) // [R09] [R08]
		else $error("Boundary instruction on internal chain not refused.");
endmodule
`default_nettype wire

// *** cis_mem_model.sv ***
// Behavioural memory system that answers the core's bus cycles.
`timescale 1ns/1ps
`default_nettype none
module cis_mem_model #(
	parameter logic [31:0] KEY = 32'h5A3C_96E1 // Read data is the address mixed with this.
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_sys_rst,
	input  wire logic                     i_bus_cycle_enable,
	input  wire cis_pkg::cis_addr_class_s i_addr_class,
	output logic [31:0]                   o_rdata,
	output logic                          o_abort
);
	// ------------------------------------------------------------
	// Idle bus pattern
	// ------------------------------------------------------------
	logic [31:0] junk_q; // Inverts every cycle so a stale capture is never mistaken for data.

	// Outside enabled cycles the bus carries garbage, not the last answer.
	always_ff @(posedge i_clk) begin
		junk_q <= i_sys_rst ? 32'hFFFF_FFFF : ~junk_q;
	end

	// ------------------------------------------------------------
	// Answer
	// ------------------------------------------------------------
	// The answer uses the address held during the enabled cycle itself, so moving
	// addresses in disabled cycles never count as new requests.
	// No late-phase latch sits on the address pins; early changes are tolerated.
	assign o_rdata = i_bus_cycle_enable ? (i_addr_class.addr ^ KEY) : junk_q;
	assign o_abort = i_bus_cycle_enable ? i_addr_class.addr[5] : junk_q[0];
endmodule
`default_nettype wire

// *** tb_cis_core_if.sv ***
// Self-checking testbench for the core pin-boundary sampling block.
`timescale 1ns/1ps
`default_nettype none
module tb_cis_core_if;
	localparam logic [31:0] RD_KEY = 32'h5A3C_96E1; // Read data mixing value.
	logic        i_clk;
	logic        rst;
	logic        rn;  // Core reset, active low.
	logic [31:0] ca;  // One word drives address class and all side inputs.
	logic        en;  // Bus cycle enable.
	logic [8:0]  ins; // Instruction valid, code and chain.
	logic [31:0] rdata;
	logic        abort;
	cis_pkg::cis_addr_class_s o_addr_class;
	cis_pkg::cis_debug_in_s   o_debug_sampled;
	logic [1:0]  o_next_transfer_type;
	logic [31:0] o_wdata;
	logic [31:0] o_core_rdata;
	logic        o_scan_serial_out;
	logic        o_size_error;
	logic        o_core_abort;
	logic        o_core_irq;
	logic        o_core_fiq;
	logic        o_bus_enable_seen;
	logic        o_debug_tick_seen;
	logic        o_debug_serial_out;
	logic        o_instr_refused;
	logic        o_clamp_active;
	// Expected state, advanced once for every rising edge.
	logic [31:0] oa, ert, ewd;
	logic [7:0]  esh, esq;
	logic [1:0]  ety, edbg;
	logic        eab, eirq, efiq, ebs, ets, edo, eref, eso;
	int          n_mismatch;
	int          checked;

	cis_core_if #(.SCAN_LEN(8), .DBG_W(8), .CLAMP_SUPPORT(1'b0)) i_cis_core_if (
		.i_clk(i_clk), .i_sys_rst(rst), .i_core_reset_n(rn),
		.i_scan_shift_select(ca[21]), .i_scan_serial_in(ca[22]),
		.o_scan_serial_out(o_scan_serial_out), .i_bus_cycle_enable(en),
		.i_debug_tick_enable(ca[18]), .i_abort(abort), .i_rdata(rdata),
		.i_debug_in({ca[19], ca[20]}), .i_debug_instr_valid(ins[8]),
		.i_debug_instr(ins[7:4]), .i_debug_chain(ins[3:0]),
		.i_normal_interrupt_request_n(ca[16]), .i_fast_interrupt_request_n(ca[17]),
		.i_core_addr_class({ca, ca[2], ca[1:0], ca[4:3], ca[6]}),
		.i_core_next_transfer_type(ca[25:24]), .i_core_wdata(~ca),
		.o_addr_class(o_addr_class), .o_next_transfer_type(o_next_transfer_type),
		.o_wdata(o_wdata), .o_size_error(o_size_error), .o_core_abort(o_core_abort),
		.o_core_rdata(o_core_rdata), .o_core_irq(o_core_irq), .o_core_fiq(o_core_fiq),
		.o_bus_enable_seen(o_bus_enable_seen), .o_debug_tick_seen(o_debug_tick_seen),
		.o_debug_sampled(o_debug_sampled), .o_debug_serial_out(o_debug_serial_out),
		.o_instr_refused(o_instr_refused), .o_clamp_active(o_clamp_active)
	);
	cis_mem_model #(.KEY(RD_KEY)) i_cis_mem_model (
		.i_clk(i_clk), .i_sys_rst(rst), .i_bus_cycle_enable(en),
		.i_addr_class(o_addr_class), .o_rdata(rdata), .o_abort(abort)
	);

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// The tests take about 100 cycles; a twelvefold margin cuts a hang short.
	initial begin
		#(1200 * 100);
		n_mismatch++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic refused(input logic [3:0] i, input logic [3:0] c);
		return (((i == cis_pkg::INSTR_EXTEST) || (i == cis_pkg::INSTR_SAMPLE) ||
			(i == cis_pkg::INSTR_PRELOAD)) && ((c == cis_pkg::CHAIN_CORE_A) ||
			(c == cis_pkg::CHAIN_CORE_B))) || (i == cis_pkg::INSTR_CLAMP) ||
			(i == cis_pkg::INSTR_HIGHZ) || (i == cis_pkg::INSTR_CLAMPZ);
	endfunction
	// Mirrors one rising edge, using the inputs that stood through the cycle it closes.
	task automatic model_edge();
		if (ca[18]) begin
			edbg = {ca[19], ca[20]};
			edo = esh[0];
			esh = {ca[20], esh[7:1]};
			if (ins[8]) eref = refused(ins[7:4], ins[3:0]);
		end
		ebs = en;
		ets = ca[18];
		eso = esq[7];
		if (ca[21]) esq = {esq[6:0], ca[22]};
		if (!rn) {oa, ert, eab, ety, ewd, eirq, efiq} = '0;
		else begin
			if (en) begin
				ert = oa ^ RD_KEY;
				eab = oa[5];
				ety = ca[25:24];
				ewd = ~ca;
			end
			oa = ca;
			eirq = ~ca[16];
			efiq = ~ca[17];
		end
	endtask
	task automatic check_all();
		chk("addr_class", 64'(o_addr_class), 64'({oa, oa[2],
			(oa[1:0] == 2'h3) ? cis_pkg::SIZE_WORD : oa[1:0], oa[4:3], oa[6]}));
		chk("size_error", 64'(o_size_error), 64'(oa[1:0] == cis_pkg::SIZE_BAD));
		chk("rdata", 64'({o_core_abort, o_core_rdata}), 64'({eab, ert}));
		chk("type_wdata", 64'({o_next_transfer_type, o_wdata}), 64'({ety, ewd}));
		chk("irq", 64'({o_core_irq, o_core_fiq}), 64'({eirq, efiq}));
		chk("enables", 64'({o_bus_enable_seen, o_debug_tick_seen}), 64'({ebs, ets}));
		chk("debug", 64'({o_debug_sampled, o_debug_serial_out}), 64'({edbg, edo}));
		chk("scan", 64'(o_scan_serial_out), 64'(eso));
		chk("refused", 64'(o_instr_refused), 64'(eref));
		chk("clamp", 64'(o_clamp_active), 64'(1'b0));
	endtask
	// One cycle: mirror the edge, drive the next inputs, then check settled outputs.
	task automatic cyc(input logic [31:0] a, input logic e, input logic [8:0] n, input logic r);
		@(posedge i_clk);
		model_edge();
		ca <= a;
		en <= e;
		ins <= n;
		rn <= r;
		#10;
		check_all();
	endtask
	task automatic end_sim();
		$display("Counts: checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		logic [3:0] codes [7];
		codes = '{cis_pkg::INSTR_EXTEST, cis_pkg::INSTR_SAMPLE, cis_pkg::INSTR_PRELOAD,
			cis_pkg::INSTR_CLAMP, cis_pkg::INSTR_HIGHZ, cis_pkg::INSTR_CLAMPZ, 4'hE};
		{rst, rn, ca, en, ins} = {1'b1, 1'b1, 32'h0003_0000, 1'b0, 9'h000};
		{oa, ert, ewd, esh, esq, ety, edbg} = '0;
		{eab, eirq, efiq, ebs, ets, edo, eref, eso} = '0;
		n_mismatch = 0;
		checked = 0;
		repeat (8) @(posedge i_clk);
		rst <= 1'b0;
		// Capture only on enabled edges while addresses and side inputs keep moving.
		for (int i = 0; i < 40; i++) cyc(32'h1234_5678 ^ (i * 32'h0049_2493), (i % 3) != 1, 9'h000, 1'b1);
		$display("Test capture done");
		// Debug ticks and scan shifting back to back, long enough to reach both outputs.
		for (int i = 0; i < 20; i++)
			cyc({9'h0, i[0] ^ i[2], 1'b1, i[1], i[0], 1'b1, 18'h3_0000 | 18'(i)}, 1'b1, 9'h000, 1'b1);
		$display("Test shift done");
		// The six instruction codes and 4'hE on chains 0 to 3; chain 3 entries come without a tick.
		for (int k = 0; k < 28; k++) cyc({13'h0, (k % 4) != 3, 18'h3_0000}, 1'b0, {1'b1, codes[k / 4], 4'(k % 4)}, 1'b1);
		$display("Test instructions done");
		// Core reset asserted between edges must clear the core side at once.
		cyc(32'hFFFE_FFFF, 1'b1, 9'h000, 1'b1);
		#30;
		rn = 1'b0;
		{oa, ert, eab, ety, ewd, eirq, efiq} = '0;
		#10;
		check_all();
		cyc(32'h8765_4321, 1'b1, 9'h000, 1'b1);
		for (int i = 0; i < 4; i++) cyc(32'h0003_0000 | i, 1'b1, 9'h000, 1'b1);
		$display("Test core reset done");
		end_sim();
	end
endmodule
`default_nettype wire
